// ---- src/tms_bus_target.sv ----
// serial-bus target, alarm and standby control of the temperature monitor
`timescale 1ns/1ps
`default_nettype none
`include "tms_defs.svh"
module tms_bus_target
  import tms_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       linkClk,
  input  wire logic       sclPin,
  input  wire logic       sdaPin,
  output logic            sdaPinOut,
  output logic            sdaPinOe,
  input  wire logic [1:0] addrStrapA,
  input  wire logic [1:0] addrStrapB,
  input  wire logic       standbyPinN,
  output logic            alarmPinOut,
  output logic            alarmPinOe,
  output logic            convEnable,
  output logic            convStart,
  input  wire logic       convBusy,
  input  wire logic       convDone,
  input  wire logic [7:0] tempLocal,
  input  wire logic [7:0] tempRemote,
  input  wire logic [4:0] limitCond
);

  ////////////////////////////////////////////////////////////////////////////
  // link domain declarations

  tms_line_if line ();

  tms_link_e  state;
  tms_byte_t  shift;
  logic [3:0] bitCnt;
  logic [1:0] wrCount;
  logic       dirRead;
  logic       araSel;
  logic       txBit;
  logic       wrTgl;
  logic       wrIsPtr;
  tms_byte_t  wrByte;
  logic       rdTgl;
  logic       rdIsAra;
  logic       araTgl;
  logic [1:0] alertSync;
  logic [1:0] validSync;
  logic       addrHit;
  logic       araHit;

  ////////////////////////////////////////////////////////////////////////////
  // core domain declarations

  logic [1:0] strapASync;
  logic [1:0] strapBSync;
  logic [1:0] strapA1;
  logic [1:0] strapB1;
  logic [1:0] stbySync;
  logic [1:0] strapWait;
  logic       addrValid;
  logic [6:0] ownAddr;
  logic [2:0] wrTglSync;
  logic [2:0] rdTglSync;
  logic [2:0] araTglSync;
  logic       wrEvt;
  logic       rdEvt;
  logic       araEvt;
  tms_byte_t  pointer;
  tms_byte_t  cfg;
  tms_byte_t  localVal;
  tms_byte_t  remoteVal;
  logic [4:0] flags;
  logic       alarmLatch;
  logic       oneShotAct;
  logic       trigger;
  logic       statusRd;
  tms_byte_t  rdHold;
  tms_byte_t  regMux;
  logic       pinHigh;

  ////////////////////////////////////////////////////////////////////////////
  // line front end

  tms_line_front u_front (
    .linkClk (linkClk),
    .rst     (rst),
    .sclPin  (sclPin),
    .sdaPin  (sdaPin),
    .line    (line.front)
  );

  ////////////////////////////////////////////////////////////////////////////
  // core to link level crossings

  // own address is static once valid, so the valid flag guards it
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      alertSync <= 2'h0;
      validSync <= 2'h0;
    end else begin
      alertSync <= {alertSync[0], alarmPinOe};
      validSync <= {validSync[0], addrValid};
    end
  end

  assign addrHit = validSync[1] && (shift[7:1] == ownAddr); // RULE5
  // only an alarming device takes the alert response address
  assign araHit  = alertSync[1] && (shift[7:1] == `TMS_ARA_ADDR); // RULE17

  ////////////////////////////////////////////////////////////////////////////
  // link byte engine

  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      state    <= TMS_IDLE;
      shift    <= 8'h00;
      bitCnt   <= 4'h0;
      wrCount  <= 2'h0;
      dirRead  <= 1'b0;
      araSel   <= 1'b0;
      txBit    <= 1'b1;
      sdaPinOe <= 1'b0;
      wrTgl    <= 1'b0;
      wrIsPtr  <= 1'b0;
      wrByte   <= 8'h00;
      rdTgl    <= 1'b0;
      rdIsAra  <= 1'b0;
      araTgl   <= 1'b0;
    end else if (line.startSeen) begin
      // a start anywhere aborts the byte and reopens addressing
      state    <= TMS_ADDR; // RULE28
      bitCnt   <= 4'h0;
      wrCount  <= 2'h0;
      sdaPinOe <= 1'b0;
    end else if (line.stopSeen) begin
      state    <= TMS_IDLE; // RULE28
      sdaPinOe <= 1'b0; // RULE9
    end else begin
      case (state)
        TMS_ADDR: begin
          if (line.sclRise) begin
            shift  <= {shift[6:0], line.sdaLevel}; // RULE4
            bitCnt <= bitCnt + 4'h1;
          end else if (line.sclFall && bitCnt == `TMS_BITS_BYTE) begin
            if (addrHit || araHit) begin
              dirRead  <= shift[0]; // RULE10
              araSel   <= araHit && !addrHit;
              sdaPinOe <= 1'b1; // RULE5
              state    <= TMS_AACK;
              if (shift[0]) begin
                rdIsAra <= araHit && !addrHit;
                rdTgl   <= ~rdTgl;
              end
            end else begin
              state <= TMS_IGN; // RULE27
            end
          end
        end
        TMS_AACK: begin
          if (line.sclFall) begin
            bitCnt <= 4'h0;
            if (dirRead) begin
              // answer from the core arrived during the acknowledge clock
              shift    <= {rdHold[6:0], 1'b1};
              txBit    <= rdHold[7];
              sdaPinOe <= ~rdHold[7];
              state    <= TMS_TX; // RULE14
            end else begin
              sdaPinOe <= 1'b0;
              state    <= TMS_RX;
            end
          end
        end
        TMS_RX: begin
          if (line.sclRise) begin
            shift  <= {shift[6:0], line.sdaLevel};
            bitCnt <= bitCnt + 4'h1;
          end else if (line.sclFall && bitCnt == `TMS_BITS_BYTE) begin
            if (wrCount < `TMS_WR_BYTES_MAX) begin
              wrIsPtr  <= (wrCount == 2'h0); // RULE12
              wrByte   <= shift;
              wrTgl    <= ~wrTgl;
              wrCount  <= wrCount + 2'h1;
              sdaPinOe <= 1'b1; // RULE6
              state    <= TMS_RACK;
            end else begin
              // a third byte is left unacknowledged
              state <= TMS_IGN; // RULE11
            end
          end
        end
        TMS_RACK: begin
          if (line.sclFall) begin
            sdaPinOe <= 1'b0;
            bitCnt   <= 4'h0;
            state    <= TMS_RX;
          end
        end
        TMS_TX: begin
          if (line.sclRise) begin
            bitCnt <= bitCnt + 4'h1;
            // released one seen low: another target won arbitration
            if (araSel && txBit && !line.sdaLevel) begin
              sdaPinOe <= 1'b0; // RULE18
              state    <= TMS_IGN;
            end
          end else if (line.sclFall) begin
            if (bitCnt == `TMS_BITS_BYTE) begin
              sdaPinOe <= 1'b0;
              state    <= TMS_TACK;
            end else begin
              txBit    <= shift[7]; // RULE7
              sdaPinOe <= ~shift[7];
              shift    <= {shift[6:0], 1'b1};
            end
          end
        end
        TMS_TACK: begin
          if (line.sclRise) begin
            if (araSel) begin
              araTgl <= ~araTgl; // RULE19
            end
            // one byte per read whatever the master answers
            state <= TMS_IGN; // RULE11
          end
        end
        TMS_IDLE: begin
          sdaPinOe <= 1'b0;
        end
        TMS_IGN: begin
          sdaPinOe <= 1'b0;
        end
        default: begin
          state    <= TMS_IDLE;
          sdaPinOe <= 1'b0;
        end
      endcase
    end
  end

  // open drain: the data level driven is always low
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      sdaPinOut <= 1'b0;
    end else begin
      sdaPinOut <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and strap capture

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strapA1    <= 2'h0;
      strapB1    <= 2'h0;
      strapASync <= 2'h0;
      strapBSync <= 2'h0;
      stbySync   <= 2'h3;
    end else begin
      strapA1    <= addrStrapA;
      strapB1    <= addrStrapB;
      strapASync <= strapA1;
      strapBSync <= strapB1;
      stbySync   <= {stbySync[0], standbyPinN};
    end
  end

  assign pinHigh = stbySync[1];

  // later strap changes are ignored once the address is valid
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strapWait <= 2'h0;
      addrValid <= 1'b0;
      ownAddr   <= 7'h00;
    end else if (!addrValid) begin
      if (strapWait != `TMS_STRAP_SETTLE) begin
        strapWait <= strapWait + 2'h1;
      end else begin
        addrValid <= 1'b1; // RULE1
        case (strapASync) // RULE2
          TMS_STRAP_LOW: begin
            ownAddr[6:3] <= `TMS_ADDR_HI_LOW;
            ownAddr[2:0] <= `TMS_ADDR_LO_LOW + {1'b0, strapBSync};
          end
          TMS_STRAP_NC: begin
            ownAddr[6:3] <= `TMS_ADDR_HI_NC;
            ownAddr[2:0] <= `TMS_ADDR_LO_NC + {1'b0, strapBSync};
          end
          default: begin
            ownAddr[6:3] <= `TMS_ADDR_HI_HIGH;
            ownAddr[2:0] <= `TMS_ADDR_LO_HIGH + {1'b0, strapBSync};
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link to core event crossings

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrTglSync  <= 3'h0;
      rdTglSync  <= 3'h0;
      araTglSync <= 3'h0;
    end else begin
      wrTglSync  <= {wrTglSync[1:0], wrTgl};
      rdTglSync  <= {rdTglSync[1:0], rdTgl};
      araTglSync <= {araTglSync[1:0], araTgl};
    end
  end

  assign wrEvt  = wrTglSync[2] ^ wrTglSync[1];
  assign rdEvt  = rdTglSync[2] ^ rdTglSync[1];
  assign araEvt = araTglSync[2] ^ araTglSync[1];

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  // write-side offsets differ from read-side ones
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pointer <= 8'h00;
      cfg     <= `TMS_CFG_RESET; // RULE23
      trigger <= 1'b0;
    end else begin
      trigger <= 1'b0;
      if (wrEvt) begin
        if (wrIsPtr) begin
          pointer <= wrByte; // RULE12
        end else if (pointer == `TMS_REG_CFG_WR) begin
          cfg <= wrByte & `TMS_CFG_USED; // RULE13 RULE15
        end else if (pointer == `TMS_REG_ONESHOT) begin
          // data byte itself is thrown away
          trigger <= cfg[`TMS_CFG_STANDBY_PIN_N_BIT] & pinHigh; // RULE22 RULE24
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion control

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      oneShotAct <= 1'b0;
      convStart  <= 1'b0;
      convEnable <= 1'b0;
    end else begin
      convStart <= trigger; // RULE22
      if (trigger) begin
        oneShotAct <= 1'b1;
      end else if (convDone || !pinHigh) begin
        oneShotAct <= 1'b0; // RULE24
      end
      // dropping enable abandons a conversion in flight
      convEnable <= pinHigh &
                    (~cfg[`TMS_CFG_STANDBY_PIN_N_BIT] | oneShotAct); // RULE20
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      localVal  <= 8'h00;
      remoteVal <= 8'h00;
    end else if (convDone && convEnable) begin
      localVal  <= tempLocal; // RULE20
      remoteVal <= tempRemote;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags and alarm

  // a condition present in the read cycle keeps its flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags <= 5'h00;
    end else begin
      flags <= limitCond | (flags & ~{5{statusRd}}); // RULE26
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarmLatch <= 1'b0;
    end else if (|flags) begin
      alarmLatch <= 1'b1; // RULE25
    end else if (araEvt && !(|limitCond)) begin
      alarmLatch <= 1'b0; // RULE19
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarmPinOe  <= 1'b0;
      alarmPinOut <= 1'b0;
    end else begin
      alarmPinOe  <= alarmLatch & ~cfg[`TMS_CFG_MASK_BIT]; // RULE16 RULE23
      alarmPinOut <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  always_comb begin
    case (pointer)
      `TMS_REG_LOCAL:  regMux = localVal;
      `TMS_REG_REMOTE: regMux = remoteVal;
      `TMS_REG_STATUS: regMux = {convBusy, flags, 2'h0};
      `TMS_REG_CFG_RD: regMux = cfg;
      default:         regMux = 8'h00; // RULE15
    endcase
  end

  // rdHold stays put until the next request, so the link samples it safely
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdHold   <= 8'hff;
      statusRd <= 1'b0;
    end else begin
      statusRd <= 1'b0;
      if (rdEvt) begin
        if (rdIsAra) begin
          rdHold <= {ownAddr, 1'b0}; // RULE17
        end else begin
          rdHold   <= regMux; // RULE14
          statusRd <= (pointer == `TMS_REG_STATUS); // RULE26
        end
      end
    end
  end

  // bus logic never looks at standby, so it serves in both modes
  // RULE21 holds by construction of the link engine above

endmodule
`default_nettype wire

// ---- pkg/tms_defs.svh ----
// constants and behaviour notes for the temperature monitor bus target
// Notes on behaviour
// (RULE1) strap levels are captured once after power-up and then frozen
// (RULE2) two three-level straps select one of nine 7-bit addresses
// (RULE3) the master opens each transfer with data falling while clock high
// (RULE4) after start eight bits arrive: address msb first, then direction
// (RULE5) a matching address is acknowledged by holding data low on clock 9
// (RULE6) every byte is eight data clocks plus one acknowledge clock
// (RULE7) data moves only while clock is low; rising data at clock high stops
// (RULE8) the master ends a write with a stop on the tenth clock
// (RULE9) a read ends with master no-acknowledge then stop; device releases data
// (RULE10) the first byte fixes direction; changing it needs a new start
// (RULE11) writes carry one or two bytes; reads return exactly one byte
// (RULE12) the first written byte always loads the register pointer
// (RULE13) a second written byte goes to the register the pointer selects
// (RULE14) a read returns the selected register without a pointer write first
// (RULE15) read and write use different pointer values for one register
// (RULE16) alarm pin pulls low on any out-of-limit or open-sensor condition
// (RULE17) on the alert response address the alarming device returns its address
// (RULE18) alert response collisions resolve by arbitration; lowest address wins
// (RULE19) after answering, the alarm releases once its cause has cleared
// (RULE20) standby by pin low or config bit 6; running conversion is dropped
// (RULE21) the serial interface keeps working in both standby modes
// (RULE22) config bit 6 with pin high: write to 0x0f starts one conversion
// (RULE23) config bit 7 masks the alarm output; reset value zero
// (RULE24) a triggered conversion returns to standby; the written byte is dropped
// (RULE25) any of the five flags sets the alarm latch
// (RULE26) status read clears only flags whose condition has gone
// (RULE27) an unmatched address is not acknowledged; wait for next start
// (RULE28) start or stop inside a byte aborts and awaits a new address
`ifndef TMS_DEFS_SVH
`define TMS_DEFS_SVH
`define TMS_REG_LOCAL    8'h00
`define TMS_REG_REMOTE   8'h01
`define TMS_REG_STATUS   8'h02
`define TMS_REG_CFG_RD   8'h03
`define TMS_REG_CFG_WR   8'h09
`define TMS_REG_ONESHOT  8'h0f
`define TMS_CFG_RESET    8'h00
`define TMS_CFG_MASK_BIT 7
`define TMS_CFG_STANDBY_PIN_N_BIT 6
`define TMS_CFG_USED     8'hc0
`define TMS_STAT_BUSY    7
`define TMS_STAT_FLAG_LO 2
`define TMS_ARA_ADDR     7'h0c
`define TMS_ADDR_HI_LOW  4'h3
`define TMS_ADDR_HI_NC   4'h5
`define TMS_ADDR_HI_HIGH 4'h9
`define TMS_ADDR_LO_LOW  3'h0
`define TMS_ADDR_LO_NC   3'h1
`define TMS_ADDR_LO_HIGH 3'h4
`define TMS_BITS_BYTE    4'h8
`define TMS_WR_BYTES_MAX 2'h2
`define TMS_STRAP_SETTLE 2'h3
`endif

// ---- pkg/tms_pkg.sv ----
// shared types of the temperature monitor bus target
package tms_pkg;
  typedef enum logic [1:0] {
    TMS_STRAP_LOW  = 2'h0,
    TMS_STRAP_NC   = 2'h1,
    TMS_STRAP_HIGH = 2'h2
  } tms_strap_e;
  typedef enum logic [2:0] {
    TMS_IDLE = 3'h0,
    TMS_ADDR = 3'h1,
    TMS_AACK = 3'h3,
    TMS_RX   = 3'h2,
    TMS_RACK = 3'h6,
    TMS_TX   = 3'h7,
    TMS_TACK = 3'h5,
    TMS_IGN  = 3'h4
  } tms_link_e;
  typedef logic [7:0] tms_byte_t;
endpackage

// ---- pkg/tms_line_if.sv ----
// line events from the bus front end to the byte engine
`timescale 1ns/1ps
`default_nettype none
interface tms_line_if;
  logic sclRise;
  logic sclFall;
  logic sdaLevel;
  logic startSeen;
  logic stopSeen;
  modport front (output sclRise, sclFall, sdaLevel, startSeen, stopSeen);
  modport engine (input sclRise, sclFall, sdaLevel, startSeen, stopSeen);
endinterface
`default_nettype wire

// ---- src/tms_line_front.sv ----
// synchronises the bus pins and detects edges, start and stop
`timescale 1ns/1ps
`default_nettype none
module tms_line_front
  import tms_pkg::*;
(
  input  wire logic  linkClk,
  input  wire logic  rst,
  input  wire logic  sclPin,
  input  wire logic  sdaPin,
  tms_line_if.front  line
);
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic       sclLast;
  logic       sdaLast;

  // first stage feeds only the second
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
    end else begin
      sclSync <= {sclSync[0], sclPin};
      sdaSync <= {sdaSync[0], sdaPin};
    end
  end

  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      sclLast <= 1'b1;
      sdaLast <= 1'b1;
    end else begin
      sclLast <= sclSync[1];
      sdaLast <= sdaSync[1];
    end
  end

  assign line.sclRise   = sclSync[1] & ~sclLast;
  assign line.sclFall   = ~sclSync[1] & sclLast;
  assign line.sdaLevel  = sdaSync[1];
  // data edges with clock high mark frame bounds
  assign line.startSeen = sclSync[1] & sclLast & sdaLast & ~sdaSync[1]; // RULE3
  assign line.stopSeen  = sclSync[1] & sclLast & ~sdaLast & sdaSync[1]; // RULE7
endmodule
`default_nettype wire

// ---- test/tms_bus_target_assertions.sv ----
// concurrent checks on the temperature monitor bus target ports
`timescale 1ns/1ps
`default_nettype none
module tms_bus_target_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic sclPin,
  input wire logic sdaPinOe,
  input wire logic standbyPinN,
  input wire logic alarmPinOut,
  input wire logic alarmPinOe,
  input wire logic convEnable,
  input wire logic convStart,
  input wire logic convDone
);
  // one-shot in flight: start seen, completion not yet
  logic shotOpen;
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      shotOpen <= 1'b0;
    else if (convStart)
      shotOpen <= 1'b1;
    else if (convDone)
      shotOpen <= 1'b0;
  ////////////////////////////////////////////////////////////
  property p_rel_reset;
    @(posedge core_clk) disable iff (rst)
      $fell(rst) |-> !alarmPinOe && !convEnable && !convStart;
  endproperty
  a_rel_reset: assert property (p_rel_reset)
    else $error("outputs active at reset release");
  property p_alarm_drive;
    @(posedge core_clk) disable iff (rst) alarmPinOe |-> !alarmPinOut;
  endproperty
  a_alarm_drive: assert property (p_alarm_drive)
    else $error("alarm driven high");
  // the bus clock low phase must cover the whole sync delay
  property p_sda_move;
    @(posedge linkClk) disable iff (rst) $changed(sdaPinOe) |-> !sclPin;
  endproperty
  a_sda_move: assert property (p_sda_move)
    else $error("data moved while bus clock high");
  property p_ack_hold;
    @(posedge linkClk) disable iff (rst)
      $rose(sdaPinOe) |=> sdaPinOe [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("data drive too short");
  property p_pulse;
    @(posedge core_clk) disable iff (rst) convStart |=> !convStart;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("start pulse too long");
  property p_pin_block;
    @(posedge core_clk) disable iff (rst)
      !standbyPinN [*6] |-> !convStart && !convEnable;
  endproperty
  a_pin_block: assert property (p_pin_block)
    else $error("converter runs with standby pin low");
  property p_start_enable;
    @(posedge core_clk) disable iff (rst) convStart |-> ##[0:3] convEnable;
  endproperty
  a_start_enable: assert property (p_start_enable)
    else $error("start without converter enable");
  property p_shot_end;
    @(posedge core_clk) disable iff (rst)
      shotOpen && convDone |-> ##[1:4] !convEnable;
  endproperty
  a_shot_end: assert property (p_shot_end)
    else $error("no return to standby after single conversion");
  c_shot: cover property (@(posedge core_clk) convStart);
  c_alarm: cover property (@(posedge core_clk) $rose(alarmPinOe));
  c_ack: cover property (@(posedge linkClk) $rose(sdaPinOe));
endmodule
bind tms_bus_target tms_bus_target_assertions u_tms_bus_target_assertions (
  .core_clk(core_clk), .rst(rst), .linkClk(linkClk), .sclPin(sclPin),
  .sdaPinOe(sdaPinOe), .standbyPinN(standbyPinN), .alarmPinOut(alarmPinOut),
  .alarmPinOe(alarmPinOe), .convEnable(convEnable), .convStart(convStart),
  .convDone(convDone));
`default_nettype wire

// ---- test/tms_smbus_host.sv ----
// bit-level bus master model for the temperature monitor target
`timescale 1ns/1ps
`default_nettype none
module tms_smbus_host
  import tms_pkg::*;
(
  input  wire logic linkClk,
  input  wire logic sda,
  output var logic  scl,
  output var logic  sdaOe
);
  // bus clock stands high and data released between frames
  initial begin
    scl = 1'b1;
    sdaOe = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // quarter bit: longer than the target's sync and answer delay
  task automatic tick();
    repeat (4) @(posedge linkClk);
  endtask
  task automatic bitx(input logic b, output logic r);
    tick();
    sdaOe <= !b;
    tick();
    scl <= 1'b1;
    tick();
    r = sda;
    tick();
    scl <= 1'b0;
  endtask
  task automatic xbyte(input tms_byte_t d, input logic m,
                       output tms_byte_t q, output logic ak);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(m, ak);
  endtask
  // a read drives the inverted first byte: zeros stand in for a rival target
  task automatic xfer(input logic [6:0] a, input logic rd, input int n,
                      input tms_byte_t b[3], output tms_byte_t q,
                      output logic [3:0] ak);
    tms_byte_t d;
    ak = 4'hf;
    q = 8'h00;
    tick();
    sdaOe <= 1'b1;
    tick();
    scl <= 1'b0;
    xbyte({a, rd}, 1'b1, d, ak[0]);
    if (rd)
      xbyte(~b[0], 1'b1, q, ak[1]);
    else
      for (int i = 0; i < n; i++) xbyte(b[i], 1'b1, d, ak[i+1]);
    tick();
    sdaOe <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sdaOe <= 1'b0;
    tick();
  endtask
endmodule
`default_nettype wire

// ---- test/temp_monitor_smbus_slave_tb.sv ----
// self-checking bench for the temperature monitor bus target
`timescale 1ns/1ps
`default_nettype none
module temp_monitor_smbus_slave_tb
  import tms_pkg::*;
;
  logic       core_clk = 1'b0, linkClk = 1'b0, rst = 1'b1;
  logic       scl, hostOe, sdaOut, sdaOe, alarmOut, alarmOe, convEn;
  logic       standbyN = 1'b1, convStart, convBusy = 1'b0, convDone = 1'b0;
  logic [1:0] strapA = 2'h0, strapB = 2'h0;
  logic [4:0] cond = 5'h00;
  logic [3:0] ak;
  logic [6:0] own;
  tms_byte_t  tLocal = 8'h00, tRemote = 8'h00, q, v, tl;
  int         nFail = 0, nTests = 0, nStart = 0, n0;
  // pulled-up data line
  wire        sda = !(hostOe || (sdaOe && !sdaOut));
  tms_smbus_host u_tms_smbus_host (
    .linkClk(linkClk), .sda(sda), .scl(scl), .sdaOe(hostOe));
  tms_bus_target u_tms_bus_target (
    .core_clk(core_clk), .rst(rst), .linkClk(linkClk), .sclPin(scl),
    .sdaPin(sda), .sdaPinOut(sdaOut), .sdaPinOe(sdaOe),
    .addrStrapA(strapA), .addrStrapB(strapB), .standbyPinN(standbyN),
    .alarmPinOut(alarmOut), .alarmPinOe(alarmOe), .convEnable(convEn),
    .convStart(convStart), .convBusy(convBusy), .convDone(convDone),
    .tempLocal(tLocal), .tempRemote(tRemote), .limitCond(cond));
  always #25 core_clk = ~core_clk;
  always #32 linkClk = ~linkClk;
  always @(posedge core_clk) if (convStart === 1'b1) nStart++;
  ////////////////////////////////////////////////////////////
  function automatic logic [6:0] addrOf(input int a, b);
    // low bits step from 0, 1 or 4 by the second strap
    return {a == 0 ? 4'h3 : a == 1 ? 4'h5 : 4'h9, 3'(a * a + b)};
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, exp);
    nTests++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finishTest();
    $display("checks %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic xf(input logic [6:0] a, input logic rd, input int n,
                    input tms_byte_t p, d);
    u_tms_smbus_host.xfer(a, rd, n, '{p, d, d}, q, ak);
  endtask
  task automatic rdReg(input tms_byte_t p, exp, input string what);
    xf(own, 1'b0, 1, p, 8'h00);
    xf(own, 1'b1, 0, 8'h00, 8'h00);
    chk(what, q, exp);
  endtask
  task automatic done(input tms_byte_t a, b);
    @(posedge core_clk);
    convDone <= 1'b1;
    tLocal <= a;
    tRemote <= b;
    @(posedge core_clk);
    convDone <= 1'b0;
  endtask
  task automatic doReset(input int a, b);
    @(posedge core_clk);
    rst <= 1'b1;
    strapA <= 2'(a);
    strapB <= 2'(b);
    cyc(8);
    rst <= 1'b0;
    cyc(12);
    own = addrOf(a, b);
  endtask
  // a hang ends the run as a failure
  initial begin
    #5000000;
    nFail++;
    finishTest();
  end
  initial begin
    void'($urandom(23));
    for (int i = 0; i < 9; i++) begin
      doReset(i / 3, i % 3);
      rdReg(8'h03, 8'h00, "cfg reset");
      chk("own ack", 8'(ak[0]), 8'h00);
      xf(7'h0c, 1'b1, 0, 8'h00, 8'h00);
      chk("ara idle", 8'(ak[0]), 8'h01);
      @(posedge core_clk) strapA <= 2'((i / 3 + 1) % 3);
      xf(addrOf((i / 3 + 1) % 3, i % 3), 1'b1, 0, 8'h00, 8'h00);
      chk("other addr", 8'(ak[0]), 8'h01);
      xf(own, 1'b1, 0, 8'h00, 8'h00);
      chk("kept addr", 8'(ak[0]), 8'h00);
      chk("data free", 8'(sdaOe), 8'h00);
    end
    $display("test straps done");
    doReset($urandom % 3, $urandom % 3);
    v = 8'($urandom);
    xf(own, 1'b0, 3, 8'h09, v);
    chk("data acks", 8'(ak), 8'h08);
    rdReg(8'h03, v & 8'hc0, "cfg");
    xf(own, 1'b1, 0, 8'h00, 8'h00);
    chk("reread", q, v & 8'hc0);
    rdReg(8'h09, 8'h00, "write ptr");
    $display("test registers done");
    xf(own, 1'b0, 2, 8'h09, 8'h00);
    cyc(6);
    chk("run", 8'(convEn), 8'h01);
    tl = 8'($urandom);
    done(tl, ~tl);
    rdReg(8'h00, tl, "local");
    rdReg(8'h01, ~tl, "remote");
    @(posedge core_clk) standbyN <= 1'b0;
    cyc(6);
    chk("pin standby_pin_n", 8'(convEn), 8'h00);
    done(~tl, tl);
    rdReg(8'h00, tl, "kept");
    @(posedge core_clk) standbyN <= 1'b1;
    xf(own, 1'b0, 2, 8'h09, 8'h40);
    cyc(6);
    chk("cfg standby_pin_n", 8'(convEn), 8'h00);
    n0 = nStart;
    xf(own, 1'b0, 2, 8'h0f, 8'($urandom));
    chk("shot", 8'(nStart - n0), 8'h01);
    chk("shot run", 8'(convEn), 8'h01);
    done(8'h00, 8'h00);
    cyc(6);
    chk("shot end", 8'(convEn), 8'h00);
    rdReg(8'h03, 8'h40, "cfg kept");
    @(posedge core_clk) standbyN <= 1'b0;
    cyc(6);
    n0 = nStart;
    xf(own, 1'b0, 2, 8'h0f, 8'h00);
    chk("blocked", 8'(nStart - n0), 8'h00);
    @(posedge core_clk) standbyN <= 1'b1;
    $display("test standby done");
    xf(own, 1'b0, 2, 8'h09, 8'h00);
    v = {1'($urandom), 5'(1 << ($urandom % 5)), 2'b00};
    @(posedge core_clk);
    cond <= v[6:2];
    convBusy <= v[7];
    cyc(6);
    chk("alarm", 8'(alarmOe), 8'h01);
    rdReg(8'h02, v, "status");
    @(posedge core_clk) cond <= 5'h00;
    xf(own, 1'b1, 0, 8'h00, 8'h00);
    xf(own, 1'b1, 0, 8'h00, 8'h00);
    chk("status clear", q, {v[7], 7'h00});
    chk("latch held", 8'(alarmOe), 8'h01);
    xf(7'h0c, 1'b1, 0, 8'hff, 8'h00);
    chk("ara lost", 8'(alarmOe), 8'h01);
    xf(7'h0c, 1'b1, 0, 8'h00, 8'h00);
    chk("ara", q, {own, 1'b0});
    cyc(6);
    chk("released", 8'(alarmOe), 8'h00);
    xf(own, 1'b0, 2, 8'h09, 8'h80);
    @(posedge core_clk) cond <= v[6:2];
    cyc(6);
    chk("masked", 8'(alarmOe), 8'h00);
    xf(7'h0c, 1'b1, 0, 8'h00, 8'h00);
    chk("ara masked", 8'(ak[0]), 8'h01);
    $display("test alarm done");
    finishTest();
  end
endmodule
`default_nettype wire
